// *** rtl/cpm_pkg.sv ***
// shared constants, types and decode functions of the charge port mode block
package cpm_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned DISCH_MS = 310;
    localparam int unsigned RELEASE_S = 15;
    localparam int unsigned HID_MS = 64;
    localparam int unsigned DISCH_CYC = DISCH_MS * (CLK_HZ / 1000);
    localparam int unsigned RELEASE_CYC = RELEASE_S * CLK_HZ;
    localparam int unsigned HID_CYC = HID_MS * (CLK_HZ / 1000);

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_WAKE = 4'h3;
    localparam logic [3:0] CODE_AUTO_DETECT = 4'h7;
    localparam logic [3:0] CODE_CDP = 4'hf;

    typedef enum logic [6:0] {
        ST_OFF = 7'h01,
        ST_RENEG = 7'h02,
        ST_PASS = 7'h04,
        ST_AUTO = 7'h08,
        ST_FORCED = 7'h10,
        ST_WAKE_IDLE = 7'h20,
        ST_WAKE_CHG = 7'h40
    } cpm_state_t;

    typedef enum logic [1:0] {
        LIM_NONE = 2'h0,
        LIM_LOW = 2'h1,
        LIM_HIGH = 2'h2,
        LIM_IDLE = 2'h3
    } cpm_limit_t;

    typedef enum logic {
        SCH_SPLIT_A = 1'h0,
        SCH_SHORTED = 1'h1
    } cpm_scheme_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } cpm_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cpm_axil_rsp_t;

    // analogue comparator and data-line detector results
    typedef struct packed {
        logic above_low;
        logic at_idle_limit;
        logic above_offset;
        logic primary_detect;
        logic shorted_attach;
        logic hid_attached;
        logic hid_activity;
    } cpm_sense_t;

    function automatic cpm_state_t mode_target(input logic [3:0] code);
        cpm_state_t t;
        t = ST_PASS;
        if (code[3:1] == 3'b000)
            t = ST_OFF;
        else if (code == CODE_WAKE)
            t = ST_WAKE_IDLE;
        else if (code[3:1] == 3'b001 || code[3:1] == 3'b011)
            t = ST_AUTO;
        else if (code[3:2] == 2'b10)
            t = ST_FORCED;
        return t;
    endfunction

    function automatic logic is_auto_code(input logic [3:0] code);
        return code[3:1] == 3'b011;
    endfunction

    function automatic logic is_wake_source(input logic [3:0] code);
        return code[3:1] == 3'b111 || code[3:1] == 3'b010;
    endfunction
endpackage

// *** rtl/cpm_sync.sv ***
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module cpm_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// *** rtl/cpm_interval_timer.sv ***
// cycle counter that flags a run held for the full interval
`timescale 1ns/1ps
module cpm_interval_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [31:0] limit_i,
    output logic done_o
);
    logic [31:0] count_reg;

    // dropping run clears the count, so the interval must be continuous
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_reg <= '0;
            done_o <= 1'b0;
        end
        else if (!run_i)
        begin
            count_reg <= '0;
            done_o <= 1'b0;
        end
        else if (count_reg + 32'h1 >= limit_i)
            done_o <= 1'b1;
        else
            count_reg <= count_reg + 32'h1;
    end
endmodule

// *** rtl/cpm_charge_port.sv ***
// charging-port mode decode, wake sequence and load-present control
`timescale 1ns/1ps
module cpm_charge_port #(
    parameter int unsigned DISCH_CYCLES = cpm_pkg::DISCH_CYC,
    parameter int unsigned RELEASE_CYCLES = cpm_pkg::RELEASE_CYC,
    parameter int unsigned HID_CYCLES = cpm_pkg::HID_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic mode_select_a_i,
    input wire logic mode_select_b_i,
    input wire logic mode_select_c_i,
    input wire logic limit_select_i,
    input wire cpm_pkg::cpm_sense_t sense_i,
    input wire cpm_pkg::cpm_axil_req_t axi_i,
    output cpm_pkg::cpm_axil_rsp_t axi_o,
    output logic load_present_n_o,
    output logic data_switch_on_o,
    output logic power_switch_on_o,
    output logic discharge_o,
    output cpm_pkg::cpm_limit_t limit_o,
    output cpm_pkg::cpm_scheme_t scheme_o
);
    import cpm_pkg::*;

    logic rst_meta_reg;
    logic rst_n_q;
    logic [3:0] code_q;
    cpm_sense_t sense_q;
    cpm_state_t state_reg;
    cpm_state_t ret_reg;
    cpm_scheme_t scheme_reg;
    logic [3:0] cur_code_reg;
    logic enable_reg;
    logic hid_hold_reg;
    logic hid_timing_reg;
    logic disch_done;
    logic release_done;
    logic hid_done;
    logic [3:0] eff_code;
    logic hid_block;
    logic accept;
    logic swap_ok;
    logic release_run;
    logic awready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [31:0] status_word;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_q <= rst_meta_reg;
        end
    end

    cpm_sync #(.W(4)) u_code_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_q),
        .d_i({mode_select_a_i, mode_select_b_i, mode_select_c_i,
            limit_select_i}),
        .q_o(code_q)
    );

    cpm_sync #(.W(7)) u_sense_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_q),
        .d_i(sense_i),
        .q_o(sense_q)
    );

    // software disable looks like the all-zero discharge pattern
    assign eff_code = enable_reg ? code_q : CODE_OFF;
    assign hid_block = hid_hold_reg && is_auto_code(eff_code) && !hid_done;
    assign accept = (eff_code != cur_code_reg) && !hid_block;
    assign swap_ok = eff_code[3:1] == 3'b111 && cur_code_reg[3:1] == 3'b111;
    assign release_run = state_reg == ST_WAKE_CHG && !sense_q.above_low;

    cpm_interval_timer u_disch_timer (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_q),
        .run_i(state_reg == ST_RENEG),
        .limit_i(DISCH_CYCLES),
        .done_o(disch_done)
    );

    cpm_interval_timer u_release_timer (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_q),
        .run_i(release_run),
        .limit_i(RELEASE_CYCLES),
        .done_o(release_done)
    );

    cpm_interval_timer u_hid_timer (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_q),
        .run_i(hid_timing_reg),
        .limit_i(HID_CYCLES),
        .done_o(hid_done)
    );

    // mode state, accepted pattern, return state and line scheme
    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_reg <= ST_OFF;
            ret_reg <= ST_OFF;
            scheme_reg <= SCH_SPLIT_A;
            cur_code_reg <= CODE_OFF;
        end
        else if (accept)
        begin
            cur_code_reg <= eff_code;
            scheme_reg <= (eff_code[3:1] == 3'b100) ? SCH_SHORTED
                : SCH_SPLIT_A;
            ret_reg <= mode_target(eff_code);
            if (swap_ok)
                state_reg <= mode_target(eff_code);
            else if (mode_target(eff_code) == ST_OFF)
                state_reg <= ST_OFF;
            else
                state_reg <= ST_RENEG;
        end
        else
        begin
            unique case (state_reg)
                ST_RENEG:
                begin
                    if (disch_done)
                        state_reg <= ret_reg;
                end
                ST_AUTO:
                begin
                    if (scheme_reg == SCH_SPLIT_A && sense_q.shorted_attach)
                    begin
                        scheme_reg <= SCH_SHORTED;
                        ret_reg <= ST_AUTO;
                        state_reg <= ST_RENEG;
                    end
                    else if (scheme_reg == SCH_SHORTED
                        && !sense_q.shorted_attach)
                        scheme_reg <= SCH_SPLIT_A;
                end
                ST_WAKE_IDLE:
                begin
                    if (sense_q.at_idle_limit)
                    begin
                        ret_reg <= ST_WAKE_CHG;
                        state_reg <= ST_RENEG;
                    end
                end
                ST_WAKE_CHG:
                begin
                    if (release_done)
                        state_reg <= ST_WAKE_IDLE;
                end
                ST_OFF, ST_PASS, ST_FORCED:
                begin
                end
            endcase
        end
    end

    // slow HID hold keeps the data path; activity arms the grace timer
    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            hid_hold_reg <= 1'b0;
            hid_timing_reg <= 1'b0;
        end
        else
        begin
            if (hid_done || !sense_q.hid_attached)
                hid_hold_reg <= 1'b0;
            else if (state_reg == ST_PASS && is_wake_source(cur_code_reg))
                hid_hold_reg <= 1'b1;
            if (!hid_block)
                hid_timing_reg <= 1'b0;
            else if (sense_q.hid_activity)
                hid_timing_reg <= 1'b1;
        end
    end

    // port outputs, one cycle behind the state
    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            load_present_n_o <= 1'b1;
            data_switch_on_o <= 1'b0;
            power_switch_on_o <= 1'b0;
            discharge_o <= 1'b1;
            limit_o <= LIM_NONE;
            scheme_o <= SCH_SPLIT_A;
        end
        else
        begin
            data_switch_on_o <= state_reg == ST_PASS;
            power_switch_on_o <= !(state_reg inside {ST_OFF, ST_RENEG});
            discharge_o <= state_reg inside {ST_OFF, ST_RENEG};
            scheme_o <= scheme_reg;
            unique case (state_reg)
                ST_OFF, ST_RENEG: limit_o <= LIM_NONE;
                ST_WAKE_IDLE: limit_o <= LIM_IDLE;
                ST_WAKE_CHG, ST_AUTO: limit_o <= LIM_HIGH;
                ST_PASS, ST_FORCED:
                    limit_o <= cur_code_reg[0] ? LIM_HIGH : LIM_LOW;
            endcase
            load_present_n_o <= !(state_reg == ST_WAKE_CHG
                || (state_reg == ST_RENEG && ret_reg == ST_WAKE_CHG)
                || (state_reg == ST_AUTO && cur_code_reg == CODE_AUTO_DETECT
                    && sense_q.above_offset)
                || (state_reg == ST_PASS && cur_code_reg == CODE_CDP
                    && (sense_q.above_offset || sense_q.primary_detect)));
        end
    end

    assign status_word = {13'h0, hid_hold_reg, scheme_reg, limit_o,
        discharge_o, power_switch_on_o, data_switch_on_o, load_present_n_o,
        cur_code_reg, state_reg};

    // register write channel: address and data taken together
    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            enable_reg <= CTRL_ENABLE_RESET;
        end
        else if (awready_reg)
        begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= RESP_OKAY;
            if (axi_i.awaddr[31:4] != 28'h0 || axi_i.awaddr[1:0] != 2'h0)
                bresp_reg <= RESP_SLVERR;
            else if (axi_i.awaddr[3:0] == ADDR_CTRL && axi_i.wstrb[0])
                enable_reg <= axi_i.wdata[CTRL_ENABLE_BIT];
            else if (axi_i.awaddr[3:0] != ADDR_CTRL
                && axi_i.awaddr[3:0] != ADDR_STATUS)
                bresp_reg <= RESP_SLVERR;
        end
        else if (bvalid_reg)
        begin
            if (axi_i.bready)
                bvalid_reg <= 1'b0;
        end
        else if (axi_i.awvalid && axi_i.wvalid)
            awready_reg <= 1'b1;
    end

    // register read channel
    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end
        else if (arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
            if (axi_i.araddr[31:4] != 28'h0 || axi_i.araddr[1:0] != 2'h0)
                rresp_reg <= RESP_SLVERR;
            else if (axi_i.araddr[3:0] == ADDR_CTRL)
                rdata_reg <= {31'h0, enable_reg};
            else if (axi_i.araddr[3:0] == ADDR_STATUS)
                rdata_reg <= status_word;
            else
                rresp_reg <= RESP_SLVERR;
        end
        else if (rvalid_reg)
        begin
            if (axi_i.rready)
                rvalid_reg <= 1'b0;
        end
        else if (axi_i.arvalid)
            arready_reg <= 1'b1;
    end

    assign axi_o = '{awready: awready_reg, wready: awready_reg,
        bvalid: bvalid_reg, bresp: bresp_reg, arready: arready_reg,
        rvalid: rvalid_reg, rdata: rdata_reg, rresp: rresp_reg};

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_q);

    property p_data_path;
        1 |=> data_switch_on_o == ($past(state_reg) == ST_PASS);
    endproperty
    a_data_path: assert property (p_data_path)
        else $error("data switch disagrees with mode");

    property p_hid_freeze;
        hid_block |=> cur_code_reg == $past(cur_code_reg);
    endproperty
    a_hid_freeze: assert property (p_hid_freeze)
        else $error("pattern accepted while slow HID holds");

    property p_forced_quiet;
        state_reg == ST_FORCED |=> load_present_n_o;
    endproperty
    a_forced_quiet: assert property (p_forced_quiet)
        else $error("load present in forced mode");

    property p_swap;
        accept && swap_ok && state_reg == ST_PASS
            |=> state_reg == ST_PASS ##1 !discharge_o;
    endproperty
    a_swap: assert property (p_swap)
        else $error("discharge on 1111/1110 change");

    property p_auto_nodetect;
        state_reg == ST_AUTO && !cur_code_reg[0]
            |=> load_present_n_o && limit_o == LIM_HIGH;
    endproperty
    a_auto_nodetect: assert property (p_auto_nodetect)
        else $error("auto without detect misbehaves");

    property p_idle_limit;
        state_reg == ST_WAKE_IDLE |=> limit_o == LIM_IDLE;
    endproperty
    a_idle_limit: assert property (p_idle_limit)
        else $error("idle limit not applied");

    property p_wake_hit;
        state_reg == ST_WAKE_IDLE && sense_q.at_idle_limit && !accept
            |=> state_reg == ST_RENEG ##1 !load_present_n_o && discharge_o;
    endproperty
    a_wake_hit: assert property (p_wake_hit)
        else $error("idle limit hit not flagged");

    property p_wake_resume;
        state_reg == ST_RENEG && ret_reg == ST_WAKE_CHG && disch_done
            && !accept |=> state_reg == ST_WAKE_CHG ##1 limit_o == LIM_HIGH;
    endproperty
    a_wake_resume: assert property (p_wake_resume)
        else $error("wake charge not on high limit");

    property p_release;
        state_reg == ST_WAKE_CHG && release_done && !accept
            |=> state_reg == ST_WAKE_IDLE ##1 load_present_n_o;
    endproperty
    a_release: assert property (p_release)
        else $error("release did not return to idle");

    property p_release_restart;
        !release_run |=> !release_done;
    endproperty
    a_release_restart: assert property (p_release_restart)
        else $error("release interval not restarted");

    c_wake_chg: cover property (state_reg == ST_RENEG
        && ret_reg == ST_WAKE_CHG ##1 state_reg == ST_WAKE_CHG);
    c_swap: cover property (accept && swap_ok);
    c_hid_block: cover property (hid_block && hid_timing_reg);
    c_shorted: cover property (state_reg == ST_AUTO
        && scheme_reg == SCH_SHORTED);
endmodule

// *** testbench/cpm_host_model.sv ***
// host controller model: owns the mode pins and follows load present
`timescale 1ns/1ps
module cpm_host_model (
    input wire logic [3:0] cmd_i,
    input wire logic load_present_n_i,
    output logic mode_select_a_o,
    output logic mode_select_b_o,
    output logic mode_select_c_o,
    output logic limit_select_o,
    output logic main_supply_on_o
);
    // plain levels; the bench moves cmd_i only just after an edge
    assign {mode_select_a_o, mode_select_b_o, mode_select_c_o,
        limit_select_o} = cmd_i;
    // main supply only while load is present, low drain regulator otherwise
    assign main_supply_on_o = !load_present_n_i;
endmodule

// *** testbench/cpm_charge_port_test.sv ***
// self-checking bench of the charge port mode block
`timescale 1ns/1ps
`define CHK(g, e) \
begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
        fails++; \
        $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
    end \
end
module cpm_charge_port_test;
    import cpm_pkg::*;
    localparam int DC = 20;
    localparam int RC = 50;
    localparam int HC = 30;
    localparam int ST = DC + 10;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] cmd = 4'h0;
    logic ma, mb, mc, ls, main_on;
    cpm_sense_t sense_i = '0;
    cpm_axil_req_t axi_i = '0;
    cpm_axil_rsp_t axi_o;
    logic lp_n, dsw, psw, dis;
    cpm_limit_t lim;
    cpm_scheme_t sch;
    int fails = 0;
    int check_count = 0;
    int n;
    logic [1:0] r;
    logic [31:0] d;
    // pattern, data switch, limit, scheme checked, scheme
    logic [8:0] rows [16] = '{9'h000, 9'h020, 9'h04a, 9'h06c, 9'h094,
        9'h0b8, 9'h0ca, 9'h0ea, 9'h107, 9'h12b, 9'h146, 9'h16a, 9'h194,
        9'h1b8, 9'h1d4, 9'h1f8};
    // pattern, sense, expected load-present level
    logic [11:0] lrows [8] = '{12'hf10, 12'hf20, 12'h720, 12'h621,
        12'h221, 12'h821, 12'ha21, 12'h321};

    cpm_host_model i_host (
        .cmd_i(cmd),
        .load_present_n_i(lp_n),
        .mode_select_a_o(ma),
        .mode_select_b_o(mb),
        .mode_select_c_o(mc),
        .limit_select_o(ls),
        .main_supply_on_o(main_on)
    );

    cpm_charge_port #(
        .DISCH_CYCLES(DC),
        .RELEASE_CYCLES(RC),
        .HID_CYCLES(HC)
    ) i_dut (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .mode_select_a_i(ma),
        .mode_select_b_i(mb),
        .mode_select_c_i(mc),
        .limit_select_i(ls),
        .sense_i(sense_i),
        .axi_i(axi_i),
        .axi_o(axi_o),
        .load_present_n_o(lp_n),
        .data_switch_on_o(dsw),
        .power_switch_on_o(psw),
        .discharge_o(dis),
        .limit_o(lim),
        .scheme_o(sch)
    );

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic stop_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask

    // counts cycles with the output discharge active
    task automatic cnt_dis(input int k);
        n = 0;
        repeat (k)
        begin
            @(posedge clk_sys_i);
            if (dis === 1'b1)
                n++;
        end
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
        axi_i.awaddr <= a;
        axi_i.wdata <= v;
        axi_i.wstrb <= 4'hf;
        axi_i.awvalid <= 1'b1;
        axi_i.wvalid <= 1'b1;
        axi_i.bready <= 1'b1;
        repeat (50)
        begin
            @(posedge clk_sys_i);
            if (axi_o.awready === 1'b1)
                axi_i.awvalid <= 1'b0;
            if (axi_o.wready === 1'b1)
                axi_i.wvalid <= 1'b0;
            if (axi_o.bvalid === 1'b1)
            begin
                r = axi_o.bresp;
                axi_i.bready <= 1'b0;
                return;
            end
        end
        fails++;
        stop_test();
    endtask

    task automatic axi_rd(input logic [31:0] a);
        axi_i.araddr <= a;
        axi_i.arvalid <= 1'b1;
        axi_i.rready <= 1'b1;
        repeat (50)
        begin
            @(posedge clk_sys_i);
            if (axi_o.arready === 1'b1)
                axi_i.arvalid <= 1'b0;
            if (axi_o.rvalid === 1'b1)
            begin
                r = axi_o.rresp;
                d = axi_o.rdata;
                axi_i.rready <= 1'b0;
                return;
            end
        end
        fails++;
        stop_test();
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        stop_test();
    end

    initial
    begin
        // outputs only settle after the first edge has pulled reset through
        cyc(2);
        `CHK({lp_n, dsw, psw, dis, lim}, 6'h24)
        resetn_i <= 1'b1;
        cyc(4);
        axi_rd({28'h0, ADDR_CTRL});
        `CHK(d[0], CTRL_ENABLE_RESET)
        $display("reset test done");
        foreach (rows[i])
        begin
            cmd <= rows[i][8:5];
            cyc(ST);
            `CHK({dsw, lim}, rows[i][4:2])
            `CHK({psw, dis}, {rows[i][8:6] != 3'h0, rows[i][8:6] == 3'h0})
            `CHK(lp_n, 1'b1)
            if (rows[i][1])
                `CHK(sch, rows[i][0])
        end
        foreach (lrows[i])
        begin
            cmd <= lrows[i][11:8];
            sense_i <= lrows[i][7:1];
            cyc(ST);
            `CHK(lp_n, lrows[i][0])
        end
        $display("decode tests done");
        // wake: idle limit hit, discharge, then charge until light load
        sense_i <= 7'h60;
        cyc(6);
        `CHK({lp_n, dis, psw}, 3'b010)
        sense_i <= 7'h40;
        cyc(DC + 4);
        `CHK({lp_n, dis, psw, lim}, {3'b001, LIM_HIGH})
        sense_i <= 7'h00;
        cyc(RC - 20);
        sense_i <= 7'h40;
        cyc(1);
        sense_i <= 7'h00;
        cyc(RC - 5);
        `CHK(lp_n, 1'b0)
        cyc(15);
        `CHK({lp_n, lim}, {1'b1, LIM_IDLE})
        `CHK(main_on, 1'b0)
        cmd <= 4'hf;
        sense_i <= 7'h02;
        cyc(ST);
        cmd <= 4'h7;
        cyc(ST);
        `CHK(dsw, 1'b1)
        sense_i <= 7'h03;
        cyc(2);
        sense_i <= 7'h02;
        cyc(8);
        // restored before the hid timer runs out
        cmd <= 4'hf;
        cnt_dis(HC + ST);
        `CHK({dsw, n}, {1'b1, 32'd0})
        cmd <= 4'h7;
        cyc(5);
        sense_i <= 7'h03;
        cyc(2);
        sense_i <= 7'h02;
        cyc(HC + ST + 5);
        `CHK({dsw, lim}, {1'b0, LIM_HIGH})
        sense_i <= 7'h00;
        $display("wake and hid tests done");
        cmd <= 4'hf;
        cyc(ST);
        cmd <= 4'he;
        cnt_dis(ST);
        `CHK({n, dsw, lim}, {32'd0, 1'b1, LIM_LOW})
        cmd <= 4'hf;
        cnt_dis(ST);
        `CHK({n, lim}, {32'd0, LIM_HIGH})
        cmd <= 4'h6;
        cnt_dis(ST);
        `CHK(n inside {DC, DC + 1}, 1'b1)
        `CHK(sch, SCH_SPLIT_A)
        sense_i <= 7'h04;
        cnt_dis(ST);
        `CHK(n inside {DC, DC + 1}, 1'b1)
        `CHK(sch, SCH_SHORTED)
        sense_i <= 7'h00;
        cnt_dis(8);
        `CHK({n, sch}, {32'd0, SCH_SPLIT_A})
        $display("discharge tests done");
        axi_rd({28'h0, ADDR_STATUS});
        `CHK({r, d[10:7], d[6:0]}, {RESP_OKAY, 4'h6, ST_AUTO})
        axi_wr({28'h0, ADDR_CTRL}, 32'h0);
        cyc(ST);
        `CHK({r, dis, psw, dsw}, {RESP_OKAY, 3'b100})
        axi_wr({28'h0, ADDR_CTRL}, 32'h1);
        cyc(ST);
        `CHK(psw, 1'b1)
        axi_wr({28'h0, ADDR_STATUS}, 32'hffffffff);
        `CHK(r, RESP_OKAY)
        axi_rd(32'h8);
        `CHK({r, d}, {RESP_SLVERR, 32'h0})
        $display("register tests done");
        stop_test();
    end
endmodule
